// *** verilog/dcta_alert.sv ***
/*
 Threshold alert logic for two converter channels with an APB slave for the
 limit, status, mask and control registers. Assumes results arrive as a
 one-cycle valid pulse on mclk and the APB master is synchronous to mclk.
*/
// Implementation choice: register access over APB.
`timescale 1ns/1ps

module dcta_alert
   import dcta_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire dcta_result_t result,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic              pready,
   output logic [31:0]       prdata,
   output logic              pslverr,
   output logic              irq
);
   logic [11:0] low_limit;
   logic [11:0] high_limit;
   logic [5:0]  mask;
   logic [5:0]  status;
   logic [5:0]  next_status;
   logic [5:0]  events;
   logic        access;
   logic        wr;
   logic        rd;
   logic        soft_rst;
   logic        hard_rst;
   logic        hit;

   // Word layout: address nibble on top, payload below
   function automatic logic [15:0] word16(input logic [3:0] idx, input logic [11:0] val);
      word16 = {idx, val};
   endfunction

   function automatic logic below_low(input logic [15:0] res, input logic [11:0] lim);
      below_low = res < {lim, LOW_FILL};
   endfunction

   function automatic logic above_high(input logic [15:0] res, input logic [11:0] lim);
      above_high = res > {lim, HIGH_FILL};
   endfunction

   assign access = psel && penable && pready;
   assign wr     = access && pwrite;
   assign rd     = access && !pwrite;
   assign hit    = (paddr == ADDR_CONTROL) || (paddr == ADDR_STATUS) ||
                   (paddr == ADDR_LOW_LIMIT) || (paddr == ADDR_HIGH_LIMIT) ||
                   (paddr == ADDR_MASK);
   assign soft_rst = wr && (paddr == ADDR_CONTROL) && (pwdata[7:0] == SOFT_RESET_KEY);
   assign hard_rst = wr && (paddr == ADDR_CONTROL) && (pwdata[7:0] == HARD_RESET_KEY);

   // Per-channel compare on each result
   always_comb
   begin
      events = 6'h00;
      if (result.valid)
      begin
         events[A_UNDER_BIT] = below_low(result.chan_a, low_limit);
         events[A_OVER_BIT]  = above_high(result.chan_a, high_limit);
         events[B_UNDER_BIT] = below_low(result.chan_b, low_limit);
         events[B_OVER_BIT]  = above_high(result.chan_b, high_limit);
      end
   end

   // Sticky flags: read clears, a new event wins over the clear
   always_comb
   begin
      next_status = status;
      if ((rd && paddr == ADDR_STATUS) || soft_rst || hard_rst)
         next_status = 6'h00;
      next_status = next_status | events;
      next_status[3:2] = 2'b00;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         status <= 6'h00;
      else
         status <= next_status;
   end

   // Limits and mask
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         low_limit  <= LOW_LIMIT_RST;
         high_limit <= HIGH_LIMIT_RST;
         mask       <= MASK_RST;
      end
      else if (hard_rst)
      begin
         low_limit  <= LOW_LIMIT_RST;
         high_limit <= HIGH_LIMIT_RST;
         mask       <= MASK_RST;
      end
      else if (wr)
      begin
         if (paddr == ADDR_LOW_LIMIT)
            low_limit <= pwdata[11:0];
         else if (paddr == ADDR_HIGH_LIMIT)
            high_limit <= pwdata[11:0];
         else if (paddr == ADDR_MASK)
            mask <= pwdata[5:0];
      end
   end

   // APB: one wait state, answer on the second access cycle
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         pready <= 1'b0;
      else
         pready <= psel && penable && !pready;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (psel && penable && !pready)
      begin
         pslverr <= !hit;
         prdata  <= 32'h0000_0000;
         if (!pwrite)
         begin
            if (paddr == ADDR_CONTROL)
               prdata <= {16'h0000, word16(REG_CONTROL, 12'h000)};
            else if (paddr == ADDR_STATUS)
               prdata <= {16'h0000, word16(REG_STATUS, {6'h00, status})};
            else if (paddr == ADDR_LOW_LIMIT)
               prdata <= {16'h0000, word16(REG_LOW_LIMIT, low_limit)};
            else if (paddr == ADDR_HIGH_LIMIT)
               prdata <= {16'h0000, word16(REG_HIGH_LIMIT, high_limit)};
            else if (paddr == ADDR_MASK)
               prdata <= {16'h0000, word16(REG_MASK, {6'h00, mask})};
         end
      end
      else
      begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |(next_status & mask);
   end

   AST_B_OVER: assert property (@(posedge mclk) disable iff (rst)
      (result.valid && result.chan_b > {high_limit, HIGH_FILL}) |=> status[B_OVER_BIT])
      else $error("channel B over flag not set");
   AST_B_UNDER: assert property (@(posedge mclk) disable iff (rst)
      (result.valid && result.chan_b < {low_limit, LOW_FILL}) |=> status[B_UNDER_BIT])
      else $error("channel B under flag not set");
   AST_A_OVER: assert property (@(posedge mclk) disable iff (rst)
      (result.valid && result.chan_a > {high_limit, HIGH_FILL}) |=> status[A_OVER_BIT])
      else $error("channel A over flag not set");
   AST_A_UNDER: assert property (@(posedge mclk) disable iff (rst)
      (result.valid && result.chan_a < {low_limit, LOW_FILL}) |=> status[A_UNDER_BIT])
      else $error("channel A under flag not set");
   AST_STICKY: assert property (@(posedge mclk) disable iff (rst)
      (!(rd && paddr == ADDR_STATUS) && !soft_rst && !hard_rst) |=>
      ((status & $past(status)) == $past(status)))
      else $error("flag lost without a status read");
   AST_NO_FALSE_LOW: assert property (@(posedge mclk) disable iff (rst)
      (status[A_UNDER_BIT] == 1'b0 && result.valid && result.chan_a >= {low_limit, LOW_FILL}
       && !soft_rst) |=> !status[A_UNDER_BIT])
      else $error("low alert raised at or above limit");
   AST_NO_FALSE_HIGH: assert property (@(posedge mclk) disable iff (rst)
      (status[A_OVER_BIT] == 1'b0 && result.valid && result.chan_a <= {high_limit, HIGH_FILL})
      |=> !status[A_OVER_BIT])
      else $error("high alert raised at or below limit");
   AST_RESERVED: assert property (@(posedge mclk) disable iff (rst)
      status[3:2] == 2'b00)
      else $error("reserved status bits set");
   AST_ADDR_FIELD: assert property (@(posedge mclk) disable iff (rst)
      (psel && penable && !pready && !pwrite && paddr == ADDR_LOW_LIMIT) |=>
      (prdata[15:12] == REG_LOW_LIMIT))
      else $error("address field missing on read");
   AST_HARD: assert property (@(posedge mclk) disable iff (rst)
      hard_rst |=> (low_limit == LOW_LIMIT_RST && high_limit == HIGH_LIMIT_RST))
      else $error("hard reset left limits changed");
   AST_SOFT: assert property (@(posedge mclk) disable iff (rst)
      (soft_rst && !result.valid) |=> (status == 6'h00 && $stable(low_limit)))
      else $error("soft reset failed");

   // Flag, limit, mask, register bus and interrupt checks
   AST_B_NO_FALSE_LOW: assert property (@(posedge mclk) disable iff (rst)
      (!status[B_UNDER_BIT] && result.valid && result.chan_b >= {low_limit, LOW_FILL})
      |=> !status[B_UNDER_BIT])
      else $error("channel B low alert raised at or above limit");
   AST_B_NO_FALSE_HIGH: assert property (@(posedge mclk) disable iff (rst)
      (!status[B_OVER_BIT] && result.valid && result.chan_b <= {high_limit, HIGH_FILL})
      |=> !status[B_OVER_BIT])
      else $error("channel B high alert raised at or below limit");
   AST_A_UNDER_IDLE: assert property (@(posedge mclk) disable iff (rst)
      (!status[A_UNDER_BIT] && !result.valid)
      |=> !status[A_UNDER_BIT])
      else $error("channel A under flag set with no result");
   AST_A_OVER_IDLE: assert property (@(posedge mclk) disable iff (rst)
      (!status[A_OVER_BIT] && !result.valid)
      |=> !status[A_OVER_BIT])
      else $error("channel A over flag set with no result");
   AST_B_UNDER_IDLE: assert property (@(posedge mclk) disable iff (rst)
      (!status[B_UNDER_BIT] && !result.valid)
      |=> !status[B_UNDER_BIT])
      else $error("channel B under flag set with no result");
   AST_B_OVER_IDLE: assert property (@(posedge mclk) disable iff (rst)
      (!status[B_OVER_BIT] && !result.valid)
      |=> !status[B_OVER_BIT])
      else $error("channel B over flag set with no result");
   AST_READ_CLEARS: assert property (@(posedge mclk) disable iff (rst)
      (rd && paddr == ADDR_STATUS && !result.valid)
      |=> (status == 6'h00))
      else $error("status read left flags set");
   AST_EVENT_WINS: assert property (@(posedge mclk) disable iff (rst)
      (rd && paddr == ADDR_STATUS && result.valid && result.chan_a < {low_limit, LOW_FILL})
      |=> status[A_UNDER_BIT])
      else $error("event lost against status read");
   AST_ONLY_RESULTS_SET: assert property (@(posedge mclk) disable iff (rst)
      !result.valid
      |=> ((status & ~$past(status)) == 6'h00))
      else $error("flag set without a result");
   AST_HARD_FLAGS: assert property (@(posedge mclk) disable iff (rst)
      (hard_rst && !result.valid)
      |=> (status == 6'h00))
      else $error("hard reset left flags set");
   AST_HARD_MASK: assert property (@(posedge mclk) disable iff (rst)
      hard_rst
      |=> (mask == MASK_RST))
      else $error("hard reset left mask changed");
   AST_SOFT_HIGH: assert property (@(posedge mclk) disable iff (rst)
      soft_rst
      |=> $stable(high_limit))
      else $error("soft reset changed high limit");
   AST_SOFT_MASK: assert property (@(posedge mclk) disable iff (rst)
      soft_rst
      |=> $stable(mask))
      else $error("soft reset changed mask");
   AST_LIMITS_HOLD: assert property (@(posedge mclk) disable iff (rst)
      !wr
      |=> ($stable(low_limit) && $stable(high_limit) && $stable(mask)))
      else $error("registers changed without a write");
   AST_LOW_WRITE: assert property (@(posedge mclk) disable iff (rst)
      (wr && paddr == ADDR_LOW_LIMIT)
      |=> ({20'h00000, low_limit} == ($past(pwdata) & 32'h0000_0fff)))
      else $error("low limit write not taken");
   AST_HIGH_WRITE: assert property (@(posedge mclk) disable iff (rst)
      (wr && paddr == ADDR_HIGH_LIMIT)
      |=> ({20'h00000, high_limit} == ($past(pwdata) & 32'h0000_0fff)))
      else $error("high limit write not taken");
   AST_MASK_WRITE: assert property (@(posedge mclk) disable iff (rst)
      (wr && paddr == ADDR_MASK)
      |=> ({26'h0000000, mask} == ($past(pwdata) & 32'h0000_003f)))
      else $error("mask write not taken");
   AST_READY_PULSE: assert property (@(posedge mclk) disable iff (rst)
      pready
      |=> !pready)
      else $error("ready stood longer than one cycle");
   AST_READY_WAIT: assert property (@(posedge mclk) disable iff (rst)
      (psel && penable && !pready)
      |=> pready)
      else $error("ready missing after wait state");
   AST_READY_IDLE: assert property (@(posedge mclk) disable iff (rst)
      !(psel && penable)
      |=> !pready)
      else $error("ready raised outside an access");
   AST_SLVERR_WITH_READY: assert property (@(posedge mclk) disable iff (rst)
      pslverr
      |-> pready)
      else $error("error response without ready");
   AST_SLVERR_UNMAPPED: assert property (@(posedge mclk) disable iff (rst)
      (psel && penable && !pready && !hit)
      |=> pslverr)
      else $error("unmapped access not refused");
   AST_SLVERR_MAPPED: assert property (@(posedge mclk) disable iff (rst)
      (psel && penable && !pready && hit)
      |=> !pslverr)
      else $error("mapped access refused");
   AST_PRDATA_IDLE: assert property (@(posedge mclk) disable iff (rst)
      !pready
      |-> (prdata == 32'h0000_0000))
      else $error("read data shown outside a response");
   AST_PRDATA_UPPER: assert property (@(posedge mclk) disable iff (rst)
      pready
      |-> (prdata[31:16] == 16'h0000))
      else $error("upper read data bits set");
   AST_WRITE_NO_DATA: assert property (@(posedge mclk) disable iff (rst)
      (psel && penable && !pready && pwrite)
      |=> (prdata == 32'h0000_0000))
      else $error("read data shown on a write");
   AST_ADDR_HIGH: assert property (@(posedge mclk) disable iff (rst)
      (psel && penable && !pready && !pwrite && paddr == ADDR_HIGH_LIMIT)
      |=> (prdata[15:12] == REG_HIGH_LIMIT))
      else $error("address field missing on high limit read");
   AST_ADDR_STATUS: assert property (@(posedge mclk) disable iff (rst)
      (psel && penable && !pready && !pwrite && paddr == ADDR_STATUS)
      |=> (prdata[15:12] == REG_STATUS))
      else $error("address field missing on status read");
   AST_ADDR_CONTROL: assert property (@(posedge mclk) disable iff (rst)
      (psel && penable && !pready && !pwrite && paddr == ADDR_CONTROL)
      |=> (prdata[15:12] == REG_CONTROL))
      else $error("address field missing on control read");
   AST_READ_LOW_VALUE: assert property (@(posedge mclk) disable iff (rst)
      (psel && penable && !pready && !pwrite && paddr == ADDR_LOW_LIMIT)
      |=> (prdata[11:0] == $past(low_limit)))
      else $error("low limit read wrong");
   AST_READ_STATUS_VALUE: assert property (@(posedge mclk) disable iff (rst)
      (psel && penable && !pready && !pwrite && paddr == ADDR_STATUS)
      |=> (prdata[5:0] == $past(status)))
      else $error("status read wrong");
   AST_RESERVED_READ: assert property (@(posedge mclk) disable iff (rst)
      (psel && penable && !pready && !pwrite && paddr == ADDR_STATUS)
      |=> (prdata[11:6] == 6'h00 && prdata[3:2] == 2'b00))
      else $error("reserved status bits read nonzero");
   AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (rst)
      $stable(mask)
      |-> (irq == |(status & mask)))
      else $error("interrupt level disagrees with flags");
   AST_IRQ_EVENT: assert property (@(posedge mclk) disable iff (rst)
      (result.valid && mask[A_UNDER_BIT] && result.chan_a < {low_limit, LOW_FILL})
      |=> irq)
      else $error("unmasked event raised no interrupt");
endmodule

// *** verilog/dcta_pkg.sv ***
/*
 Package for the dual channel threshold alert block: register map, field layout,
 reset values and the result carrier. Assumes an APB register bus, 32-bit data.
*/
package dcta_pkg;
   // Register indices (byte address is four times the index)
   localparam logic [3:0]  REG_CONTROL    = 4'h2;
   localparam logic [3:0]  REG_STATUS     = 4'h3;
   localparam logic [3:0]  REG_LOW_LIMIT  = 4'h4;
   localparam logic [3:0]  REG_HIGH_LIMIT = 4'h5;
   localparam logic [3:0]  REG_MASK       = 4'h6;
   localparam logic [11:0] ADDR_CONTROL    = 12'h008;
   localparam logic [11:0] ADDR_STATUS     = 12'h00c;
   localparam logic [11:0] ADDR_LOW_LIMIT  = 12'h010;
   localparam logic [11:0] ADDR_HIGH_LIMIT = 12'h014;
   localparam logic [11:0] ADDR_MASK       = 12'h018;
   // Field positions
   localparam int ADDR_FIELD_LSB = 12;
   localparam int A_UNDER_BIT    = 0;
   localparam int A_OVER_BIT     = 1;
   localparam int B_UNDER_BIT    = 4;
   localparam int B_OVER_BIT     = 5;
   // Reset values and fills
   localparam logic [11:0] LOW_LIMIT_RST  = 12'h800;
   localparam logic [11:0] HIGH_LIMIT_RST = 12'h7ff;
   localparam logic [3:0]  LOW_FILL       = 4'h0;
   localparam logic [3:0]  HIGH_FILL      = 4'hf;
   localparam logic [5:0]  MASK_RST       = 6'h00;
   localparam logic [7:0]  SOFT_RESET_KEY = 8'h3c;
   localparam logic [7:0]  HARD_RESET_KEY = 8'hff;

   typedef struct packed {
      logic        valid;
      logic [15:0] chan_a;
      logic [15:0] chan_b;
   } dcta_result_t;
endpackage

// *** tb/dcta_host.sv ***
/*
 APB host model for the alert block.
 Assumes one clock, mclk; the bench calls xfer at a rising edge.
*/
`timescale 1ns/1ps
module dcta_host
(
   input  wire logic        mclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err, output logic tmo);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      q = prdata;
      err = pslverr;
      tmo = (n >= 20);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// *** tb/dcta_alert_bench.sv ***
/*
 Self-checking bench for the alert block.
 Assumes the host model drives APB; results are driven here.
*/
`timescale 1ns/1ps
module dcta_alert_bench
   import dcta_pkg::*;
();
   logic         mclk = 1'b0;
   logic         rst = 1'b1;
   dcta_result_t result = '0;
   logic         psel, penable, pwrite, pready, pslverr, irq, last_err;
   logic [11:0]  paddr, lo, hi;
   logic [31:0]  pwdata, prdata, q;
   logic [15:0]  va, vb;
   int           n_checks = 0;
   int           n_mismatch = 0;
   always #50 mclk = ~mclk;
   dcta_alert dcta_alert_i (.mclk(mclk), .rst(rst), .result(result), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq));
   dcta_host dcta_host_i (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      logic t;
      dcta_host_i.xfer(w, a, d, q, last_err, t);
      if (t)
      begin
         n_mismatch++;
         give_verdict();
      end
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic send(input logic [15:0] a, input logic [15:0] b);
      result <= '{1'b1, a, b};
      @(posedge mclk);
      result.valid <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask
   function automatic logic [31:0] exp_st(logic [15:0] a, b, logic [11:0] l, h);
      return {16'h0, 4'h3, 6'h0, b > {h, 4'hf}, b < {l, 4'h0}, 2'b00,
              a > {h, 4'hf}, a < {l, 4'h0}};
   endfunction
   function automatic logic [15:0] pick(int k, logic [11:0] l, h);
      case (k % 5)
         0: return {l, 4'h0};
         1: return {l, 4'h0} - 16'h1;
         2: return {h, 4'hf};
         3: return {h, 4'hf} + 16'h1;
         default: return 16'($urandom);
      endcase
   endfunction
   initial
   begin
      void'($urandom(32'haa7b44c2));
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      rc(ADDR_LOW_LIMIT, 32'h4800);
      rc(ADDR_HIGH_LIMIT, 32'h57ff);
      rc(ADDR_STATUS, 32'h3000);
      $display("test reset done");
      for (int i = 0; i < 30; i++)
      begin
         lo = 12'($urandom);
         hi = 12'($urandom);
         acc(1'b1, ADDR_LOW_LIMIT, {16'h0, REG_LOW_LIMIT, lo});
         acc(1'b1, ADDR_HIGH_LIMIT, {16'h0, REG_HIGH_LIMIT, hi});
         rc(ADDR_HIGH_LIMIT, {16'h0, REG_HIGH_LIMIT, hi});
         va = pick(i, lo, hi);
         vb = pick(i + 2, lo, hi);
         send(va, vb);
         rc(ADDR_STATUS, exp_st(va, vb, lo, hi));
      end
      $display("test compare done");
      acc(1'b1, ADDR_LOW_LIMIT, 32'h4100);
      acc(1'b1, ADDR_HIGH_LIMIT, 32'h5200);
      acc(1'b1, ADDR_MASK, 32'h6011);
      send(16'h0000, 16'hffff);
      send(16'h1500, 16'h1500);
      chk({31'h0, irq}, 32'h1);
      rc(ADDR_STATUS, 32'h3021);
      repeat (2) @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
      send(16'h1500, 16'hffff);
      chk({31'h0, irq}, 32'h0);
      rc(ADDR_STATUS, 32'h3020);
      rc(ADDR_STATUS, 32'h3000);
      $display("test sticky done");
      send(16'h0000, 16'h0000);
      acc(1'b1, ADDR_CONTROL, 32'h203c);
      rc(ADDR_STATUS, 32'h3000);
      rc(ADDR_LOW_LIMIT, 32'h4100);
      acc(1'b1, ADDR_CONTROL, 32'h20ff);
      rc(ADDR_LOW_LIMIT, 32'h4800);
      rc(ADDR_HIGH_LIMIT, 32'h57ff);
      rc(ADDR_MASK, 32'h6000);
      acc(1'b0, 12'h03c, 32'h0);
      chk({q[31:1], last_err}, 32'h1);
      $display("test resets done");
      give_verdict();
   end
endmodule
